// ==== dv/ext_timebase.sv ====
// Test clock source on the clock pin and oscillator tick source
`timescale 1ns/1ps
`default_nettype none
module ext_timebase (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Pulse request
  input  wire logic       start_i,
  input  wire logic [7:0] count_i,
  // Outputs
  output logic            pin_o,
  output logic            tick_o,
  output logic            busy_o
);
  logic [7:0] left_reg;
  logic [3:0] ph_reg;
  logic [1:0] div_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      left_reg <= 8'h00;
      ph_reg   <= 4'h0;
      div_reg  <= 2'h0;
    end
    else
    begin
      div_reg <= div_reg + 2'h1;
      if (start_i)
      begin
        left_reg <= count_i;
        ph_reg   <= 4'h0;
      end
      else if (left_reg != 8'h00)
      begin
        ph_reg <= (ph_reg == 4'hB) ? 4'h0 : ph_reg + 4'h1;
        if (ph_reg == 4'hB)
          left_reg <= left_reg - 8'h01;
      end
    end
  end
  // High 300 ns then low 300 ns per pulse
  assign pin_o  = (left_reg != 8'h00) && (ph_reg < 4'h6);
  assign tick_o = (div_reg == 2'h3);
  assign busy_o = (left_reg != 8'h00);
endmodule : ext_timebase
`default_nettype wire

// ==== dv/rtc_ctl_assertions.sv ====
// Checker on the ports of the RTC control block
`timescale 1ns/1ps
`default_nettype none
module rtc_ctl_checker #(
  parameter int UPPER_WIDTH = 13,
  parameter int UPPER_TICK  = 4160
) (
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // APB
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  // Pins
  input wire logic        CLOCK_OUTPUT_PIN_O,
  input wire logic        CLOCK_OUTPUT_PIN_OE_O,
  input wire logic        LOAD_LOAD_CAP_SELECT_O,
  input wire logic        IRQ_O
);
  logic       commit;
  logic       ctl_wr;
  logic       stop_reg;
  logic [2:0] sel_reg;
  logic [1:0] quiet_reg;
  assign commit = PSEL && PENABLE && PREADY && PWRITE;
  assign ctl_wr = commit && PADDR == rtc_ctl_pkg::OFF_CTRL_ONE;
  // Track stop and clock output selection as written
  always_ff @(posedge CLK_I)
  begin
    if (RST_I || (ctl_wr && PWDATA[4]))
    begin
      stop_reg  <= 1'b0;
      sel_reg   <= rtc_ctl_pkg::RST_CLOCK_OUTPUT_PIN_SEL;
      quiet_reg <= 2'h0;
    end
    else
    begin
      if (ctl_wr)
        stop_reg <= PWDATA[5];
      if (commit && PADDR == rtc_ctl_pkg::OFF_CLOCK_OUTPUT_PIN_SEL)
        sel_reg <= PWDATA[2:0];
      quiet_reg <= commit ? 2'h0 :
                   (quiet_reg == 2'h3) ? 2'h3 : quiet_reg + 2'h1;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  ready_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  wait_state_a: assert property (PSEL && PENABLE && !$past(PENABLE) |=> PREADY)
    else $error("ready not one cycle after access");
  ready_cause_a: assert property (PREADY |-> PSEL && $past(PENABLE))
    else $error("ready without access");
  err_unmapped_a: assert property (PREADY && PADDR > 8'h10 |-> PSLVERR)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (PREADY && PADDR[1:0] == 2'h0 &&
    PADDR <= 8'h10 |-> !PSLVERR)
    else $error("mapped access refused");
  ctrl_zero_a: assert property (PREADY && !PWRITE && PADDR == 8'h00 |->
    PRDATA[31:8] == 24'h0 && !PRDATA[6] && !PRDATA[4] && !PRDATA[3])
    else $error("control reserved bits not zero");
  test_pin_in_a: assert property (ctl_wr && PWDATA[7] && !PWDATA[4] |->
    ##[1:2] !CLOCK_OUTPUT_PIN_OE_O)
    else $error("clock pin still driven in test mode");
  soft_reset_a: assert property (ctl_wr && PWDATA[4] |->
    ##[1:2] (CLOCK_OUTPUT_PIN_OE_O && !LOAD_LOAD_CAP_SELECT_O && !IRQ_O))
    else $error("soft reset left pins set");
  slow_clk_off_a: assert property (stop_reg && sel_reg >= 3'h2 &&
    quiet_reg == 2'h3 && CLOCK_OUTPUT_PIN_OE_O |-> !CLOCK_OUTPUT_PIN_O)
    else $error("slow clock output while stopped");
  cover property (ctl_wr && PWDATA[4]);
  cover property (ctl_wr && PWDATA[7]);
  cover property (PREADY && PSLVERR);
  cover property ($rose(IRQ_O));
endmodule : rtc_ctl_checker
bind rtc_ctl rtc_ctl_checker #(
  .UPPER_WIDTH(UPPER_WIDTH), .UPPER_TICK(UPPER_TICK)
) rtc_ctl_checker_i (
  .CLK_I(CLK_I), .RST_I(RST_I), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O),
  .CLOCK_OUTPUT_PIN_OE_O(CLOCK_OUTPUT_PIN_OE_O), .LOAD_LOAD_CAP_SELECT_O(LOAD_LOAD_CAP_SELECT_O),
  .IRQ_O(IRQ_O)
);
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the RTC control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        err;
  } row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        start = 1'b0;
  logic [7:0]  cnt = 8'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        xtal;
  logic        ext_pin;
  logic        busy;
  logic        clock_output_pin;
  logic        oe;
  logic        cap;
  logic        irq;
  logic        pin;
  logic [31:0] rd;
  logic        er;
  logic        prev;
  int          errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          n;
  int          tog;
  row_s rows[14] = '{'{1'b0, 8'h00, 32'h0, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 1'b0}, '{1'b0, 8'h04, 32'h0, 1'b0},
    '{1'b0, 8'h10, 32'h0, 1'b0}, '{1'b1, 8'h00, 32'h4B, 1'b0},
    '{1'b0, 8'h00, 32'h03, 1'b0}, '{1'b1, 8'h00, 32'h20, 1'b0},
    '{1'b1, 8'h0C, 32'hD1E05, 1'b0}, '{1'b0, 8'h0C, 32'hD1E05, 1'b0},
    '{1'b1, 8'h00, 32'h22, 1'b0}, '{1'b0, 8'h0C, 32'h211E05, 1'b0},
    '{1'b0, 8'h00, 32'h22, 1'b0}, '{1'b1, 8'h14, 32'h5A, 1'b1},
    '{1'b0, 8'h14, 32'h0, 1'b1}};
  // Stop, clock output selection, output expected to toggle
  logic [4:0]  ck[5] = '{5'h11, 5'h13, 5'h14, 5'h1A, 5'h05};
  // Test pulses and expected seconds
  logic [15:0] tp[4] = '{16'h1F00, 16'h0101, 16'h3F01, 16'h0102};
  assign pin = oe ? clock_output_pin : ext_pin;
  rtc_ctl #(.UPPER_WIDTH(6), .UPPER_TICK(8)) rtc_ctl_i (
    .CLK_I(clk), .RST_I(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .XTAL_TICK_I(xtal),
    .CLOCK_OUTPUT_PIN_I(pin), .CLOCK_OUTPUT_PIN_O(clock_output_pin), .CLOCK_OUTPUT_PIN_OE_O(oe),
    .LOAD_LOAD_CAP_SELECT_O(cap), .IRQ_O(irq));
  ext_timebase ext_timebase_i (.clk_i(clk), .rst_i(rst), .start_i(start),
    .count_i(cnt), .pin_o(ext_pin), .tick_o(xtal), .busy_o(busy));
  initial forever #25 clk = ~clk;
  task automatic conclude();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, string nm);
    apb(1'b0, a, 32'h0);
    check(nm, e, rd);
  endtask : rdc
  task automatic pulse(input logic [7:0] k);
    @(posedge clk);
    start <= 1'b1;
    cnt <= k;
    @(posedge clk);
    start <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    repeat (4) @(posedge clk);
  endtask : pulse
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    check("oe_rst", 32'h1, {31'h0, oe});
    check("irq_rst", 32'h0, {31'h0, irq});
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data);
      if (!rows[i].wr)
        check("rdata", rows[i].data, rd);
      check("slverr", {31'h0, rows[i].err}, {31'h0, er});
    end
    repeat (300) @(posedge clk);
    rdc(8'h0C, 32'h211E05, "frozen");
    foreach (ck[i])
    begin
      wr(8'h00, {26'h0, ck[i][4], 5'h00});
      wr(8'h10, {29'h0, ck[i][3:1]});
      repeat (4) @(posedge clk);
      tog = 0;
      prev = clock_output_pin;
      repeat (100)
      begin
        @(posedge clk);
        if (clock_output_pin !== prev)
          tog++;
        prev = clock_output_pin;
      end
      check("clk_runs", {31'h0, ck[i][0]}, {31'h0, tog > 0});
    end
    wr(8'h00, 32'h20);
    wr(8'h04, 32'h3);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h3B);
    wr(8'h00, 32'h04);
    n = 0;
    while (irq !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    check("tick_wait", 32'h1, {31'h0, n >= 110 && n <= 140});
    rdc(8'h04, 32'h3, "status");
    rdc(8'h0C, 32'h100, "wrap");
    wr(8'h04, 32'h1);
    repeat (2) @(posedge clk);
    check("irq_clr", 32'h0, {31'h0, irq});
    wr(8'h08, 32'h2);
    repeat (2) @(posedge clk);
    check("irq_mask", 32'h1, {31'h0, irq});
    wr(8'h04, 32'h2);
    repeat (2) @(posedge clk);
    check("irq_clr", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h80);
    repeat (2) @(posedge clk);
    check("pin_dir", 32'h0, {31'h0, oe});
    wr(8'h00, 32'hA0);
    wr(8'h00, 32'h80);
    wr(8'h0C, 32'h80000);
    foreach (tp[i])
    begin
      pulse(tp[i][15:8]);
      rdc(8'h0C, {24'h000800, tp[i][7:0]}, "test_time");
    end
    wr(8'h00, 32'h81);
    repeat (2) @(posedge clk);
    check("cap_pin", 32'h1, {31'h0, cap});
    wr(8'h00, 32'h58);
    repeat (2) @(posedge clk);
    check("pin_dir", 32'h1, {31'h0, oe});
    check("cap_pin", 32'h0, {31'h0, cap});
    rdc(8'h00, 32'h0, "ctrl");
    rdc(8'h0C, 32'h0, "time");
    rdc(8'h08, 32'h0, "mask");
    conclude();
  end
endmodule : tb
`default_nettype wire

// ==== hdl/prescale_stage.sv ====
// Clearable divider stage that pulses once when its count reaches a point
`timescale 1ns/1ps
`default_nettype none
module prescale_stage #(
  parameter int WIDTH   = 6,
  parameter int TICK_AT = 32
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             clr_i,
  input  wire logic             en_i,
  // Status
  output logic      [WIDTH-1:0] count_o,
  output logic                  tick_o
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             tick;
  } stage_s;

  stage_s st_reg;
  stage_s st_next;
  logic [WIDTH-1:0] inc;

  if (WIDTH < 1 || TICK_AT < 1 || TICK_AT >= (1 << WIDTH))
  begin : g_bad_tick
    $error("prescale_stage: TICK_AT out of range");
  end

  assign inc = st_reg.count + WIDTH'(1);

  always_comb
  begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (clr_i)
      st_next.count = '0;
    else if (en_i)
    begin
      st_next.count = inc;
      st_next.tick  = (inc == WIDTH'(TICK_AT));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign count_o = st_reg.count;
  assign tick_o  = st_reg.tick;

endmodule : prescale_stage
`default_nettype wire

// ==== hdl/rtc_ctl.sv ====
// RTC control register one with prescaler, stop, test mode and APB slave
//
// Contract
// - Bit 7 selects external clock test mode
// - Test mode turns clock pin into timebase
// - Test clock drives prescaler to 1 Hz
// - Stop zeroes upper and test prescalers until stop cleared
// - Test: first tick 32 edges, then 64
// - Bit 5 stops clock, clears upper divider chain
// - Stop holds upper stages, lowest two run
// - Stop suppresses clock output below 8 kHz
// - Stopped time accepts writes, stays frozen
// - First tick about 0.507813 s after release
// - Bit 4 soft resets, reads zero
// - Bit 2 enables correction interrupt pulses
// - Bit 1 selects 12 or 24 hours
// - Bit 0 selects load capacitance
// - Soft reset restores reset values, except the lowest two prescaler stages and the pin sample
`timescale 1ns/1ps
`default_nettype none
module rtc_ctl #(
  parameter int UPPER_WIDTH = rtc_ctl_pkg::UPPER_W,
  parameter int UPPER_TICK  = rtc_ctl_pkg::UPPER_TICK_AT
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Oscillator timebase enable
  input  wire logic        XTAL_TICK_I,
  // Clock output pin
  input  wire logic        CLOCK_OUTPUT_PIN_I,
  output logic             CLOCK_OUTPUT_PIN_O,
  output logic             CLOCK_OUTPUT_PIN_OE_O,
  // Oscillator and interrupt
  output logic             LOAD_LOAD_CAP_SELECT_O,
  output logic             IRQ_O
);

  if (UPPER_WIDTH < 6 || UPPER_TICK < 1
      || UPPER_TICK >= (1 << UPPER_WIDTH))
  begin : g_bad_upper
    $error("rtc_ctl: upper prescaler parameters out of range");
  end

  typedef struct packed {
    rtc_ctl_pkg::ctrl_s        ctrl;
    logic [rtc_ctl_pkg::IRQ_W-1:0] status;
    logic [rtc_ctl_pkg::IRQ_W-1:0] mask;
    logic [2:0]                clk_sel;
    logic [5:0]                sec;
    logic [5:0]                min;
    logic [4:0]                hour;
    logic [rtc_ctl_pkg::LOW_W-1:0] low;
    logic                      pin_prev;
    logic                      one_hz;
    logic                      clock_output_pin;
    logic                      clock_output_pin_oe;
    logic                      irq;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
  } state_s;

  state_s st_reg;
  state_s st_next;

  logic                   upper_en;
  logic                   test_en;
  logic [UPPER_WIDTH-1:0] upper_cnt;
  logic                   upper_tick;
  logic [rtc_ctl_pkg::TEST_W-1:0] test_cnt;
  logic                   test_tick;
  logic                   sec_tick;
  logic [14:0]            presc_bits;
  logic                   pin_rise;
  logic                   apb_setup_acc;
  logic                   apb_commit;
  logic                   wr_commit;
  logic                   hit;
  logic                   soft_rst;
  logic [31:0]            rd_word;
  logic [7:0]             ctrl_byte;
  logic [4:0]             hour_disp;
  logic                   hour_pm;
  logic [4:0]             hour_mod;
  logic [rtc_ctl_pkg::IRQ_W-1:0] irq_set;
  state_s                 rst_state;

  // Rising edges on the clock pin replace the oscillator in test mode
  assign pin_rise = st_reg.ctrl.ext_clock_test_mode & CLOCK_OUTPUT_PIN_I & ~st_reg.pin_prev;
  assign upper_en = ~st_reg.ctrl.ext_clock_test_mode & XTAL_TICK_I
                    & (&st_reg.low);
  assign test_en  = pin_rise;

  // Upper chain of the crystal prescaler, held clear while stopped
  prescale_stage #(
    .WIDTH   (UPPER_WIDTH),
    .TICK_AT (UPPER_TICK)
  ) u_upper (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .clr_i   (st_reg.ctrl.stop | soft_rst),
    .en_i    (upper_en),
    .count_o (upper_cnt),
    .tick_o  (upper_tick)
  );

  // Test mode prescaler counting pin edges
  prescale_stage #(
    .WIDTH   (rtc_ctl_pkg::TEST_W),
    .TICK_AT (rtc_ctl_pkg::TEST_TICK_AT)
  ) u_test (
    .clk_i   (CLK_I),
    .rst_i   (RST_I),
    .clr_i   (st_reg.ctrl.stop | soft_rst | ~st_reg.ctrl.ext_clock_test_mode),
    .en_i    (test_en),
    .count_o (test_cnt),
    .tick_o  (test_tick)
  );

  // One second tick from whichever chain is active
  assign sec_tick = st_reg.ctrl.ext_clock_test_mode ? test_tick : upper_tick;

  assign presc_bits = 15'({upper_cnt, st_reg.low});

  // APB decode
  assign apb_setup_acc = PSEL & PENABLE & ~st_reg.pready;
  assign apb_commit    = PSEL & PENABLE & st_reg.pready;
  assign hit = (PADDR == rtc_ctl_pkg::OFF_CTRL_ONE)
             | (PADDR == rtc_ctl_pkg::OFF_IRQ_STATUS)
             | (PADDR == rtc_ctl_pkg::OFF_IRQ_MASK)
             | (PADDR == rtc_ctl_pkg::OFF_TIME)
             | (PADDR == rtc_ctl_pkg::OFF_CLOCK_OUTPUT_PIN_SEL);
  assign wr_commit = apb_commit & PWRITE & hit;
  assign soft_rst  = wr_commit & (PADDR == rtc_ctl_pkg::OFF_CTRL_ONE)
                   & PWDATA[rtc_ctl_pkg::BIT_SOFT_RST];

  // Control byte read view, unused and reset bits read zero
  always_comb
  begin
    ctrl_byte = 8'h00;
    ctrl_byte[rtc_ctl_pkg::BIT_EXT_CLOCK_TEST_MODE] = st_reg.ctrl.ext_clock_test_mode;
    ctrl_byte[rtc_ctl_pkg::BIT_STOP]     = st_reg.ctrl.stop;
    ctrl_byte[rtc_ctl_pkg::BIT_CORR_IE]  = st_reg.ctrl.corr_ie;
    ctrl_byte[rtc_ctl_pkg::BIT_MODE_12H] = st_reg.ctrl.mode_12h;
    ctrl_byte[rtc_ctl_pkg::BIT_LOAD_CAP] = st_reg.ctrl.load_cap;
  end

  // Hours shown as 1 to 12 with a PM flag in 12 hour mode
  always_comb
  begin
    hour_pm  = (st_reg.hour >= rtc_ctl_pkg::HOUR_12);
    hour_mod = hour_pm ? st_reg.hour - rtc_ctl_pkg::HOUR_12 : st_reg.hour;
    if (st_reg.ctrl.mode_12h)
      hour_disp = (hour_mod == 5'h00) ? rtc_ctl_pkg::HOUR_12 : hour_mod;
    else
    begin
      hour_disp = st_reg.hour;
      hour_pm   = 1'b0;
    end
  end

  // Read data mux
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (PADDR)
      rtc_ctl_pkg::OFF_CTRL_ONE:
        rd_word[7:0] = ctrl_byte;
      rtc_ctl_pkg::OFF_IRQ_STATUS:
        rd_word[rtc_ctl_pkg::IRQ_W-1:0] = st_reg.status;
      rtc_ctl_pkg::OFF_IRQ_MASK:
        rd_word[rtc_ctl_pkg::IRQ_W-1:0] = st_reg.mask;
      rtc_ctl_pkg::OFF_TIME:
      begin
        rd_word[rtc_ctl_pkg::TIME_SEC_LSB +: 6]  = st_reg.sec;
        rd_word[rtc_ctl_pkg::TIME_MIN_LSB +: 6]  = st_reg.min;
        rd_word[rtc_ctl_pkg::TIME_HOUR_LSB +: 5] = hour_disp;
        rd_word[rtc_ctl_pkg::TIME_PM_BIT]        = hour_pm;
      end
      rtc_ctl_pkg::OFF_CLOCK_OUTPUT_PIN_SEL:
        rd_word[2:0] = st_reg.clk_sel;
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // Events of this cycle; a set beats a same-cycle write-one clear
  always_comb
  begin
    irq_set = '0;
    if (sec_tick)
    begin
      irq_set[rtc_ctl_pkg::IRQ_SEC] = 1'b1;
      if (st_reg.ctrl.corr_ie
          && st_reg.sec == rtc_ctl_pkg::SEC_MAX)
        irq_set[rtc_ctl_pkg::IRQ_CORR] = 1'b1;
    end
  end

  // Reset image of the whole state
  always_comb
  begin
    rst_state          = '0;
    rst_state.ctrl     = '0;
    rst_state.clk_sel  = rtc_ctl_pkg::RST_CLOCK_OUTPUT_PIN_SEL;
    rst_state.sec      = rtc_ctl_pkg::RST_SEC;
    rst_state.min      = rtc_ctl_pkg::RST_MIN;
    rst_state.hour     = rtc_ctl_pkg::RST_HOUR;
    rst_state.clock_output_pin_oe = 1'b1;
  end

  always_comb
  begin
    st_next          = st_reg;
    st_next.pin_prev = CLOCK_OUTPUT_PIN_I;

    // Lowest two stages keep running through stop
    if (XTAL_TICK_I & ~st_reg.ctrl.ext_clock_test_mode)
      st_next.low = st_reg.low + 2'h1;

    st_next.status = st_reg.status | irq_set;

    // Time advances only on a tick, so a stopped clock stays frozen
    if (sec_tick)
    begin
      st_next.one_hz = ~st_reg.one_hz;
      if (st_reg.sec == rtc_ctl_pkg::SEC_MAX)
      begin
        st_next.sec = 6'h00;
        if (st_reg.min == rtc_ctl_pkg::MIN_MAX)
        begin
          st_next.min = 6'h00;
          if (st_reg.hour == rtc_ctl_pkg::HOUR_MAX)
            st_next.hour = 5'h00;
          else
            st_next.hour = st_reg.hour + 5'h01;
        end
        else
          st_next.min = st_reg.min + 6'h01;
      end
      else
        st_next.sec = st_reg.sec + 6'h01;
    end

    // APB answer after one wait state
    st_next.pready  = apb_setup_acc;
    st_next.pslverr = apb_setup_acc & ~hit;
    if (apb_setup_acc)
      st_next.prdata = PWRITE ? 32'h0000_0000 : rd_word;

    if (wr_commit)
    begin
      case (PADDR)
        rtc_ctl_pkg::OFF_CTRL_ONE:
        begin
          st_next.ctrl.ext_clock_test_mode = PWDATA[rtc_ctl_pkg::BIT_EXT_CLOCK_TEST_MODE];
          st_next.ctrl.stop     = PWDATA[rtc_ctl_pkg::BIT_STOP];
          st_next.ctrl.corr_ie  = PWDATA[rtc_ctl_pkg::BIT_CORR_IE];
          st_next.ctrl.mode_12h = PWDATA[rtc_ctl_pkg::BIT_MODE_12H];
          st_next.ctrl.load_cap = PWDATA[rtc_ctl_pkg::BIT_LOAD_CAP];
        end
        rtc_ctl_pkg::OFF_IRQ_STATUS:
          // Write one to clear, a same-cycle event wins
          st_next.status = (st_reg.status
                            & ~PWDATA[rtc_ctl_pkg::IRQ_W-1:0])
                           | irq_set;
        rtc_ctl_pkg::OFF_IRQ_MASK:
          st_next.mask = PWDATA[rtc_ctl_pkg::IRQ_W-1:0];
        rtc_ctl_pkg::OFF_TIME:
        begin
          // Loads are taken whether running or stopped
          st_next.sec  = PWDATA[rtc_ctl_pkg::TIME_SEC_LSB +: 6];
          st_next.min  = PWDATA[rtc_ctl_pkg::TIME_MIN_LSB +: 6];
          st_next.hour = PWDATA[rtc_ctl_pkg::TIME_HOUR_LSB +: 5];
        end
        rtc_ctl_pkg::OFF_CLOCK_OUTPUT_PIN_SEL:
          st_next.clk_sel = PWDATA[2:0];
        default:
          st_next.mask = st_reg.mask;
      endcase
    end

    // Clock pin: input in test mode, divided output otherwise
    st_next.clock_output_pin_oe = ~st_next.ctrl.ext_clock_test_mode;
    if (st_reg.clk_sel == rtc_ctl_pkg::SEL_OFF)
      st_next.clock_output_pin = 1'b0;
    else if (st_reg.ctrl.stop
             && st_reg.clk_sel >= rtc_ctl_pkg::SEL_LOWEST_SLOW)
      st_next.clock_output_pin = 1'b0;
    else if (st_reg.clk_sel == rtc_ctl_pkg::SEL_ONE_HZ)
      st_next.clock_output_pin = st_reg.one_hz;
    else
      st_next.clock_output_pin = presc_bits[st_reg.clk_sel];

    st_next.irq = |(st_next.status & st_next.mask);

    // Software reset restores every register except the lowest two prescaler stages and the pin sample
    if (soft_rst)
    begin
      st_next         = rst_state;
      st_next.pin_prev = CLOCK_OUTPUT_PIN_I;
      st_next.low     = st_reg.low;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      st_reg           <= '0;
      st_reg.clk_sel   <= rtc_ctl_pkg::RST_CLOCK_OUTPUT_PIN_SEL;
      st_reg.sec       <= rtc_ctl_pkg::RST_SEC;
      st_reg.min       <= rtc_ctl_pkg::RST_MIN;
      st_reg.hour      <= rtc_ctl_pkg::RST_HOUR;
      st_reg.clock_output_pin_oe <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign PRDATA         = st_reg.prdata;
  assign PREADY         = st_reg.pready;
  assign PSLVERR        = st_reg.pslverr;
  assign CLOCK_OUTPUT_PIN_O       = st_reg.clock_output_pin;
  assign CLOCK_OUTPUT_PIN_OE_O    = st_reg.clock_output_pin_oe;
  assign LOAD_LOAD_CAP_SELECT_O = st_reg.ctrl.load_cap;
  assign IRQ_O          = st_reg.irq;

endmodule : rtc_ctl
`default_nettype wire

// ==== hdl/rtc_ctl_pkg.sv ====
// Package with register map, field layout and timing constants of the RTC
package rtc_ctl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_ONE   = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h08;
  localparam logic [7:0] OFF_TIME       = 8'h0C;
  localparam logic [7:0] OFF_CLOCK_OUTPUT_PIN_SEL = 8'h10;

  // Control register one bit positions
  localparam int BIT_EXT_CLOCK_TEST_MODE = 7;
  localparam int BIT_STOP     = 5;
  localparam int BIT_SOFT_RST = 4;
  localparam int BIT_CORR_IE  = 2;
  localparam int BIT_MODE_12H = 1;
  localparam int BIT_LOAD_CAP = 0;

  // Interrupt status bit positions
  localparam int IRQ_SEC  = 0;
  localparam int IRQ_CORR = 1;
  localparam int IRQ_W    = 2;

  // Time register field positions
  localparam int TIME_SEC_LSB  = 0;
  localparam int TIME_MIN_LSB  = 8;
  localparam int TIME_HOUR_LSB = 16;
  localparam int TIME_PM_BIT   = 21;

  // Reset values
  localparam logic [7:0] RST_CTRL_ONE   = 8'h00;
  localparam logic [2:0] RST_CLOCK_OUTPUT_PIN_SEL = 3'h0;
  localparam logic [5:0] RST_SEC        = 6'h00;
  localparam logic [5:0] RST_MIN        = 6'h00;
  localparam logic [4:0] RST_HOUR       = 5'h00;

  // Prescaler: two free stages, then the upper chain
  localparam int LOW_W           = 2;
  localparam int UPPER_W         = 13;
  localparam int UPPER_TICK_AT   = 4160;
  localparam int TEST_W          = 6;
  localparam int TEST_TICK_AT    = 32;

  // Clock output selections (bit index into prescaler, 1 Hz, off)
  localparam logic [2:0] SEL_LOWEST_SLOW = 3'h2;
  localparam logic [2:0] SEL_ONE_HZ      = 3'h5;
  localparam logic [2:0] SEL_OFF         = 3'h7;

  // Time limits
  localparam logic [5:0] SEC_MAX  = 6'h3B;
  localparam logic [5:0] MIN_MAX  = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [4:0] HOUR_12  = 5'h0C;

  typedef struct packed {
    logic        ext_clock_test_mode;
    logic        stop;
    logic        corr_ie;
    logic        mode_12h;
    logic        load_cap;
  } ctrl_s;

endpackage : rtc_ctl_pkg
